// [verilog/ncg_pkg.sv]
// Constants, register map and carrier types for the oscillator
// combine, gain and dither stage.
// Assumes one sample clock and a plain register port with 12-bit
// addresses and 16-bit data.
//
// How it works
// R1 - Dither bit set adds sub-LSB dither before rounding; reset value is set.
// R2 - Combine bit 0: each oscillator drives its own channel.
// R3 - Combine bit 1: both oscillator outputs are summed into one output.
// R4 - In summed mode both channels receive the same summed value.
// R5 - Gain is one minus backoff over two to the sixteenth.
// R6 - Backoff applies in both independent and summed modes.
// R7 - Nonzero channel dither level lowers gain to avoid clipping.
// R8 - Programmed backoff adds to dither backoff to form total.
// R9 - Effective gain clamps at zero instead of going negative.
// R10 - Software changes mode bits only while transmission is off.
// R11 - Software changes backoffs only while oscillator run is clear.
// R12 - Small backoffs saturate the output rather than wrap.
// R13 - Configuration register resets to 0x02.
// R14 - Each backoff register resets to 0x0003.
// R15 - Whole datapath held in reset while oscillator run is clear.
// R16 - Fixed equal pipeline latency for both oscillators.

package ncg_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int DATA_W = 16;
   localparam logic [ADDR_W-1:0] CFG_ADDR = 12'h331;
   localparam logic [ADDR_W-1:0] BO_A_ADDR = 12'h332;
   localparam logic [ADDR_W-1:0] BO_B_ADDR = 12'h334;
   localparam logic [7:0] CFG_RST = 8'h02;
   localparam logic [15:0] BO_RST = 16'h0003;
   localparam int CFG_COMBINE_BIT = 0;
   localparam int CFG_DITHER_BIT = 1;

   // ----------------------------------------------------------------
   // Datapath constants
   // ----------------------------------------------------------------
   localparam int GAIN_FRAC = 16;
   localparam logic [16:0] GAIN_ONE = 17'h10000;
   localparam int LVL_W = 4;
   localparam logic [15:0] DITH_BO_STEP = 16'h0010;
   localparam int PIPE_LAT = 3;
   localparam logic [15:0] LFSR_SEED_A = 16'hACE1;
   localparam logic [15:0] LFSR_SEED_B = 16'h1D35;
   localparam logic [15:0] LFSR_TAPS = 16'hB400;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [5:0] spare;
      logic dither_on;
      logic combine_sel;
   } ncg_cfg_s;

   typedef struct packed {
      logic we;
      logic re;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } ncg_bus_s;

endpackage : ncg_pkg

// [verilog/ncg_top.sv]
// Output conditioning for a pair of oscillators: gain backoff,
// optional summing, sub-LSB dither, rounding and saturation.
// Assumes samples, levels and the run bit come from logic on the
// same sample clock; the register port is a simple strobe bus.
//
// Added by the designer: the address-and-strobe port.

`timescale 1ns/1ps

module ncg_top
   import ncg_pkg::*;
#(
   parameter int IN_W = 16,
   parameter int OUT_W = 12
)
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic osc_run,
   input wire logic [LVL_W-1:0] chan_a_dither_level,
   input wire logic [LVL_W-1:0] chan_b_dither_level,
   input wire logic signed [IN_W-1:0] osc_a_sample,
   input wire logic signed [IN_W-1:0] osc_b_sample,
   input wire logic sample_valid,
   output logic signed [OUT_W-1:0] converter_chan_a,
   output logic signed [OUT_W-1:0] converter_chan_b,
   output logic out_valid
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   localparam int FRAC_W = IN_W - OUT_W;
   localparam int PROD_W = IN_W + 18;
   localparam int SCL_W = IN_W + 2;
   localparam int SUM_W = SCL_W + 1;
   localparam int DIT_W = SUM_W + 1;

   generate
      if (FRAC_W < 1 || FRAC_W > 15)
      begin : g_bad_width
         $error("ncg_top: IN_W must exceed OUT_W by 1 to 15 bits");
      end
   endgenerate

   localparam logic signed [DIT_W-1:0] HALF_LSB =
      DIT_W'(1) <<< (FRAC_W - 1);
   localparam logic signed [IN_W-1:0] OUT_MAX =
      IN_W'((1 << (OUT_W - 1)) - 1);
   localparam logic signed [IN_W-1:0] OUT_MIN = -OUT_MAX - IN_W'(1);

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   ncg_bus_s bus;
   ncg_cfg_s cfg_r;
   logic [15:0] bo_a_r;
   logic [15:0] bo_b_r;
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] rd_mux;
   wire hit_cfg;
   wire hit_a;
   wire hit_b;

   assign bus = '{we: reg_we, re: reg_re, addr: reg_addr, wdata: reg_wdata};
   assign hit_cfg = bus.addr == CFG_ADDR;
   assign hit_a = bus.addr == BO_A_ADDR;
   assign hit_b = bus.addr == BO_B_ADDR;

   // Unmapped addresses read as zero
   assign rd_mux = hit_cfg ? {8'h00, cfg_r} :
                   hit_a ? bo_a_r :
                   hit_b ? bo_b_r : 16'h0000;

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         cfg_r <= CFG_RST;   // [R13] [R1]
         bo_a_r <= BO_RST;   // [R14]
         bo_b_r <= BO_RST;   // [R14]
         rdata_r <= 16'h0000;
      end
      else
      begin
         if (bus.we && hit_cfg)
         begin
            cfg_r <= bus.wdata[7:0];
         end
         if (bus.we && hit_a)
         begin
            bo_a_r <= bus.wdata;
         end
         if (bus.we && hit_b)
         begin
            bo_b_r <= bus.wdata;
         end
         rdata_r <= bus.re ? rd_mux : 16'h0000;
      end
   end

   assign reg_rdata = rdata_r;

   // ----------------------------------------------------------------
   // Datapath reset
   // ----------------------------------------------------------------
   // Software is trusted to leave the mode bits alone while
   // transmitting and the backoffs alone while running, so the
   // datapath reads them live with no shadow copies. [R10] [R11]
   wire dp_rst;
   assign dp_rst = !rst_b || !osc_run;   // [R15]

   // ----------------------------------------------------------------
   // Per-oscillator gain stage (stage 1)
   // ----------------------------------------------------------------
   logic signed [IN_W-1:0] smp [2];
   logic [LVL_W-1:0] lvl [2];
   logic [15:0] bo [2];
   logic signed [SCL_W-1:0] scl_r [2];
   logic [15:0] lfsr_r [2];
   logic [FRAC_W-1:0] dith [2];

   assign smp[0] = osc_a_sample;
   assign smp[1] = osc_b_sample;
   assign lvl[0] = chan_a_dither_level;
   assign lvl[1] = chan_b_dither_level;
   assign bo[0] = bo_a_r;
   assign bo[1] = bo_b_r;

   generate
      for (genvar i = 0; i < 2; i++)
      begin : g_osc
         wire [19:0] dith_bo;
         wire [16:0] total_bo;
         wire [16:0] gain;
         wire signed [PROD_W-1:0] prod;
         wire [15:0] lfsr_nxt;

         // Dither headroom grows with the channel's dither level
         assign dith_bo = lvl[i] * DITH_BO_STEP;   // [R7]
         assign total_bo = {1'b0, bo[i]} + dith_bo[16:0];   // [R8]
         // Clamp: a backoff at or beyond unity yields zero gain
         assign gain = (total_bo >= GAIN_ONE || |dith_bo[19:17]) ?
                       17'h00000 :
                       17'(GAIN_ONE - total_bo);   // [R9] [R5]
         // Same gain path in both modes
         assign prod = smp[i] * $signed({1'b0, gain});   // [R6] [R5]

         assign lfsr_nxt = lfsr_r[i][0] ?
                           ((lfsr_r[i] >> 1) ^ LFSR_TAPS) :
                           (lfsr_r[i] >> 1);

         always_ff @(posedge sys_clk)
         begin
            if (dp_rst)
            begin
               scl_r[i] <= '0;
               lfsr_r[i] <= (i == 0) ? LFSR_SEED_A : LFSR_SEED_B;
            end
            else
            begin
               scl_r[i] <= prod[GAIN_FRAC +: SCL_W];   // [R16]
               lfsr_r[i] <= lfsr_nxt;
            end
         end

         // Uniform dither below one output LSB
         assign dith[i] = cfg_r.dither_on ?
                          lfsr_r[i][FRAC_W-1:0] :
                          '0;   // [R1]
      end
   endgenerate

   // ----------------------------------------------------------------
   // Combine and dither stage (stage 2)
   // ----------------------------------------------------------------
   logic signed [DIT_W-1:0] pre_r [2];
   logic [1:0] vld_r;
   wire signed [SUM_W-1:0] sum_ab;
   wire signed [SUM_W-1:0] mix [2];
   wire signed [DIT_W-1:0] rnd [2];

   assign sum_ab = SUM_W'(scl_r[0]) + SUM_W'(scl_r[1]);   // [R3]
   // Summed mode feeds the one sum to both channels
   assign mix[0] = cfg_r.combine_sel ? sum_ab : SUM_W'(scl_r[0]);   // [R3] [R4]
   assign mix[1] = cfg_r.combine_sel ? sum_ab : SUM_W'(scl_r[1]);   // [R2] [R4]

   // Without dither, round half up; with it, add the dither and
   // truncate. In summed mode one dither draw serves both channels
   // so they stay bit-identical.
   generate
      for (genvar i = 0; i < 2; i++)
      begin : g_rnd
         wire [FRAC_W-1:0] d_sel;
         assign d_sel = cfg_r.combine_sel ? dith[0] : dith[i];   // [R4]
         assign rnd[i] = cfg_r.dither_on ?
                         DIT_W'(mix[i]) + $signed(DIT_W'(d_sel)) :
                         DIT_W'(mix[i]) + HALF_LSB;   // [R1]

         always_ff @(posedge sys_clk)
         begin
            if (dp_rst)
            begin
               pre_r[i] <= '0;
            end
            else
            begin
               pre_r[i] <= rnd[i];   // [R16]
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Saturate and output stage (stage 3)
   // ----------------------------------------------------------------
   logic signed [OUT_W-1:0] out_r [2];
   logic out_vld_r;
   wire signed [DIT_W-1:0] shr [2];
   wire signed [OUT_W-1:0] sat [2];

   generate
      for (genvar i = 0; i < 2; i++)
      begin : g_sat
         assign shr[i] = pre_r[i] >>> FRAC_W;
         // Clip instead of wrapping when backoff is too small
         assign sat[i] = (shr[i] > DIT_W'(OUT_MAX)) ? OUT_MAX[OUT_W-1:0] :
                         (shr[i] < DIT_W'(OUT_MIN)) ? OUT_MIN[OUT_W-1:0] :
                         shr[i][OUT_W-1:0];   // [R12]

         always_ff @(posedge sys_clk)
         begin
            if (dp_rst)
            begin
               out_r[i] <= '0;
            end
            else
            begin
               out_r[i] <= sat[i];   // [R16]
            end
         end
      end
   endgenerate

   // Valid runs alongside the samples so both channels share it
   always_ff @(posedge sys_clk)
   begin
      if (dp_rst)
      begin
         vld_r <= 2'b00;
         out_vld_r <= 1'b0;
      end
      else
      begin
         vld_r <= {vld_r[0], sample_valid};   // [R16]
         out_vld_r <= vld_r[1];
      end
   end

   assign converter_chan_a = out_r[0];
   assign converter_chan_b = out_r[1];
   assign out_valid = out_vld_r;

endmodule : ncg_top

// [sim/ncg_sva.sv]
// Port checker for the oscillator combine and gain stage.
// Assumes mode and backoffs change only while osc_run is low.
`timescale 1ns/1ps
module ncg_sva
   import ncg_pkg::*;
#(
   parameter int IN_W = 16,
   parameter int OUT_W = 12
)
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic osc_run,
   input wire logic signed [IN_W-1:0] osc_a_sample,
   input wire logic sample_valid,
   input wire logic signed [OUT_W-1:0] converter_chan_a,
   input wire logic signed [OUT_W-1:0] converter_chan_b,
   input wire logic out_valid
);
   // ---
   // Shadow of the register contents
   // ---
   logic [7:0] cfg_r;
   logic [15:0] boa_r;
   logic [15:0] bob_r;
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         cfg_r <= CFG_RST;
         boa_r <= BO_RST;
         bob_r <= BO_RST;
      end
      else if (reg_we)
      begin
         if (reg_addr == CFG_ADDR)
            cfg_r <= reg_wdata[7:0];
         if (reg_addr == BO_A_ADDR)
            boa_r <= reg_wdata;
         if (reg_addr == BO_B_ADDR)
            bob_r <= reg_wdata;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   property p_vld;
      sample_valid && osc_run ##1 osc_run [*2] |=> out_valid;
   endproperty
   a_vld: assert property (p_vld)
      else $error("out_valid missing");
   property p_nvld;
      !sample_valid && osc_run ##1 osc_run [*2] |=> !out_valid;
   endproperty
   a_nvld: assert property (p_nvld)
      else $error("out_valid spurious");
   property p_clr;
      !osc_run |=> !out_valid && converter_chan_a == '0 && converter_chan_b == '0;
   endproperty
   a_clr: assert property (p_clr)
      else $error("datapath not cleared");
   property p_cfg;
      reg_re && reg_addr == CFG_ADDR |=> reg_rdata == {8'h00, cfg_r};
   endproperty
   a_cfg: assert property (p_cfg)
      else $error("config read wrong");
   property p_boa;
      reg_re && reg_addr == BO_A_ADDR |=> reg_rdata == boa_r;
   endproperty
   a_boa: assert property (p_boa)
      else $error("backoff A read wrong");
   property p_bob;
      reg_re && reg_addr == BO_B_ADDR |=> reg_rdata == bob_r;
   endproperty
   a_bob: assert property (p_bob)
      else $error("backoff B read wrong");
   property p_sum;
      out_valid && cfg_r[CFG_COMBINE_BIT] |-> converter_chan_a == converter_chan_b;
   endproperty
   a_sum: assert property (p_sum)
      else $error("summed channels differ");
   property p_zero;
      cfg_r[1:0] == 2'h0 && osc_a_sample == '0 && osc_run ##1 osc_run [*2]
         |=> converter_chan_a == '0;
   endproperty
   a_zero: assert property (p_zero)
      else $error("zero sample not zero");
   c_sum: cover property (out_valid && cfg_r[CFG_COMBINE_BIT]);
   c_dith: cover property (out_valid && cfg_r[CFG_DITHER_BIT]);
   c_stop: cover property ($fell(osc_run));
endmodule : ncg_sva

bind ncg_top ncg_sva #(.IN_W(IN_W), .OUT_W(OUT_W)) sva_u (.sys_clk(sys_clk), .rst_b(rst_b),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
   .reg_rdata(reg_rdata), .osc_run(osc_run), .osc_a_sample(osc_a_sample),
   .sample_valid(sample_valid), .converter_chan_a(converter_chan_a),
   .converter_chan_b(converter_chan_b), .out_valid(out_valid));

// [sim/testbench.sv]
// Self-checking bench for ncg_top with a cycle model of the stage.
// Assumes a three cycle sample latency and live register reads.
`timescale 1ns/1ps
module testbench;
   import ncg_pkg::*;
   typedef struct packed {logic v; logic signed [11:0] a; logic signed [11:0] b;} ncg_exp_s;
   logic sys_clk, rst_b, reg_we, reg_re, osc_run, sample_valid, out_valid, chk_on;
   logic [11:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, boa, bob;
   logic [3:0] lvl_a, lvl_b;
   logic signed [15:0] smp_a, smp_b;
   logic signed [11:0] out_a, out_b;
   logic [7:0] cfg;
   logic [31:0] seed = 32'h0000_4979;
   int error_cnt, num_checks;
   ncg_exp_s pipe [3];
   ncg_top dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
      .osc_run(osc_run), .chan_a_dither_level(lvl_a), .chan_b_dither_level(lvl_b),
      .osc_a_sample(smp_a), .osc_b_sample(smp_b), .sample_valid(sample_valid),
      .converter_chan_a(out_a), .converter_chan_b(out_b), .out_valid(out_valid));
   // ---
   // Model
   // ---
   function automatic logic [31:0] rng();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rng
   function automatic longint scl(longint s, longint bo, longint lv);
      longint g;
      g = GAIN_ONE - bo - lv * DITH_BO_STEP;
      if (g < 0)
         g = 0;
      return (s * g) >>> 16;
   endfunction : scl
   function automatic logic signed [11:0] rnd(longint v);
      longint r;
      r = (v + 8) >>> 4;
      if (r > 2047)
         r = 2047;
      if (r < -2048)
         r = -2048;
      return r[11:0];
   endfunction : rnd
   function automatic ncg_exp_s mk();
      ncg_exp_s e;
      longint xa, xb;
      xa = scl(smp_a, boa, lvl_a);
      xb = scl(smp_b, bob, lvl_b);
      e.v = sample_valid;
      e.a = cfg[0] ? rnd(xa + xb) : rnd(xa);
      e.b = cfg[0] ? rnd(xa + xb) : rnd(xb);
      return e;
   endfunction : mk
   function automatic logic [15:0] pick(logic [15:0] x);
      case (x[3:0])
         4'h0: return 16'h7FFF;
         4'h1: return 16'h8000;
         4'h2: return 16'h0000;
         default: return x;
      endcase
   endfunction : pick
   task automatic chk(logic [15:0] g, logic [15:0] e);
      num_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // Dither may move the rounded value by one step either way
   task automatic near(logic signed [11:0] g, logic signed [11:0] e);
      chk({4'h0, g}, {4'h0, (g === e + 12'sh001 || g === e - 12'sh001) ? g : e});
   endtask : near
   task automatic wr(logic [11:0] a, logic [15:0] d);
      @(posedge sys_clk);
      reg_we <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_we <= 1'b0;
   endtask : wr
   task automatic rd(logic [11:0] a, logic [15:0] e);
      @(posedge sys_clk);
      reg_re <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_re <= 1'b0;
      @(negedge sys_clk);
      chk(reg_rdata, e);
   endtask : rd
   task automatic close_out();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : close_out
   task automatic seg(int i);
      logic [15:0] tb [4];
      logic [31:0] r;
      r = rng();
      tb = '{16'h0000, 16'h0003, 16'hFFFF, r[15:0]};
      @(posedge sys_clk);
      osc_run <= 1'b0;
      @(posedge sys_clk);
      cfg = {6'h00, i[1:0]};
      boa = tb[i % 4];
      bob = tb[(i + 1) % 4];
      lvl_a <= i[2] ? r[19:16] : 4'h0;
      lvl_b <= i[2] ? 4'hF : 4'h0;
      wr(CFG_ADDR, {8'h00, cfg});
      wr(BO_A_ADDR, boa);
      wr(BO_B_ADDR, bob);
      @(posedge sys_clk);
      osc_run <= 1'b1;
      repeat (60)
      begin
         @(posedge sys_clk);
         r = rng();
         smp_a <= pick(r[15:0]);
         smp_b <= pick(r[31:16]);
         sample_valid <= r[7] | r[6];
      end
   endtask : seg
   // ---
   // Clock, model pipe and output checks
   // ---
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      pipe[1] <= pipe[0];
      pipe[2] <= pipe[1];
      pipe[0] <= mk();
      if (!rst_b || !osc_run)
         pipe <= '{default: '0};
   end
   always @(negedge sys_clk)
   begin
      if (chk_on)
      begin
         chk({15'h0, out_valid}, {15'h0, pipe[2].v});
         if (pipe[2].v && cfg[1])
         begin
            near(out_a, pipe[2].a);
            near(out_b, pipe[2].b);
         end
         if (pipe[2].v && !cfg[1])
         begin
            chk({4'h0, out_a}, {4'h0, pipe[2].a});
            chk({4'h0, out_b}, {4'h0, pipe[2].b});
         end
      end
   end
   initial
   begin
      #100000;
      error_cnt++;
      close_out();
   end
   initial
   begin
      {reg_we, reg_re, osc_run, sample_valid, chk_on, rst_b} = '0;
      {reg_addr, reg_wdata, smp_a, smp_b, lvl_a, lvl_b} = '0;
      cfg = CFG_RST;
      boa = BO_RST;
      bob = BO_RST;
      pipe = '{default: '0};
      repeat (20) @(posedge sys_clk);
      rst_b <= 1'b1;
      chk_on <= 1'b1;
      rd(CFG_ADDR, 16'h0002);
      rd(BO_A_ADDR, BO_RST);
      rd(BO_B_ADDR, BO_RST);
      rd(12'h333, 16'h0000);
      wr(CFG_ADDR, 16'hABFF);
      rd(CFG_ADDR, 16'h00FF);
      for (int i = 0; i < 8; i++)
         seg(i);
      close_out();
   end
endmodule : testbench
